// >>> verilog/dcsr_params.svh
`ifndef DCSR_PARAMS_SVH
`define DCSR_PARAMS_SVH

// Register byte offsets
`define DCSR_OFF_STATUS 8'h04
`define DCSR_OFF_BANK 8'h08
`define DCSR_OFF_TIMING_ONE 8'h10
`define DCSR_OFF_TIMING_TWO 8'h14

// Status register field
`define DCSR_STAT_READY_BIT 2

// Bank configuration field positions
`define DCSR_BANK_DRIVE_UNLOCK_BIT 23
`define DCSR_BANK_RSVD_HIGH_MSB 22
`define DCSR_BANK_RSVD_HIGH_LSB 19
`define DCSR_BANK_DRIVE_BIT 18
`define DCSR_BANK_TIMING_UNLOCK_BIT 15
`define DCSR_BANK_NARROW_BIT 14
`define DCSR_BANK_CAS_MSB 11
`define DCSR_BANK_CAS_LSB 9
`define DCSR_BANK_BANKS_MSB 6
`define DCSR_BANK_BANKS_LSB 4
`define DCSR_BANK_PAGE_MSB 2
`define DCSR_BANK_PAGE_LSB 0

// Bank configuration reset values
`define DCSR_RST_DRIVE_UNLOCK 1'h0
`define DCSR_RST_RSVD_HIGH 4'h2
`define DCSR_RST_DRIVE 1'h1
`define DCSR_BANK_RSVD_LOW 2'h3
`define DCSR_RST_TIMING_UNLOCK 1'h0
`define DCSR_RST_NARROW 1'h0
`define DCSR_RST_CAS 3'h5
`define DCSR_RST_BANKS 3'h2
`define DCSR_RST_PAGE 3'h0

// Timing register reset values are not given; neutral zero
`define DCSR_RST_TIMING_ONE 32'h0000_0000
`define DCSR_RST_TIMING_TWO 32'h0000_0000

`endif

// >>> verilog/dcsr_pkg.sv
package dcsr_pkg;
	typedef logic [31:0] dcsr_word_t;
	typedef enum logic {
		DCSR_TIM_ONE,
		DCSR_TIM_TWO
	} dcsr_timing_sel_t;
endpackage

// >>> verilog/dcsr_timing_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcsr_timing_if;
	import dcsr_pkg::*;
	logic wr_en;
	dcsr_timing_sel_t sel;
	dcsr_word_t wdata;
	logic unlock;
	dcsr_word_t data_one;
	dcsr_word_t data_two;
	modport writer (output wr_en, output sel, output wdata, output unlock,
		input data_one, input data_two);
	modport store (input wr_en, input sel, input wdata, input unlock,
		output data_one, output data_two);
endinterface
`default_nettype wire

// >>> verilog/dcsr_timing_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_params.svh"
module dcsr_timing_store #(
	parameter logic [31:0] RESET_ONE = `DCSR_RST_TIMING_ONE,
	parameter logic [31:0] RESET_TWO = `DCSR_RST_TIMING_TWO
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	dcsr_timing_if.store tif
);
	import dcsr_pkg::*;

	dcsr_word_t store_q [2];

	////////////////////////////////////////////////////////////////////////
	// One gated word per timing register
	for (genvar i = 0; i < 2; i++) begin : g_entry
		localparam logic [31:0] RST = (i == 0) ? RESET_ONE : RESET_TWO;
		logic hit;
		assign hit = tif.wr_en && (int'(tif.sel) == i);
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				store_q[i] <= RST;
			end else if (hit && tif.unlock) begin
				store_q[i] <= tif.wdata;
			end
		end
	end

	assign tif.data_one = store_q[0];
	assign tif.data_two = store_q[1];

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_timing_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tif.wr_en && !tif.unlock |=> $stable(store_q[0]) && $stable(store_q[1]))
		else $error("timing register changed while locked");
endmodule
`default_nettype wire

// >>> verilog/dcsr_top.sv
// Contract
// - Status bit 2 reads 1 only while the DLL is powered, out of reset, locked.
// - Any bank configuration write launches the SDRAM initialization sequence.
// - Drive strength bit changes only while the drive unlock bit holds 1.
// - Bit 18 selects memory drive: 0 normal, 1 weak.
// - Bit 15 gates writes to both timing registers.
// - Bit 14 selects data bus width: 0 is 32-bit, 1 is 16-bit.
// - Bits 6 to 4 encode banks: 0 one, 1 two, 2 four, 3 eight.
// - Bits 2 to 0 encode column bits: 0 eight up to 3 eleven.
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_params.svh"
module dcsr_top #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ADDR_WIDTH-1:0] reg_addr_i,
	input wire dcsr_pkg::dcsr_word_t reg_wdata_i,
	output dcsr_pkg::dcsr_word_t reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic dll_powered_up_i,
	input wire logic dll_in_reset_i,
	input wire logic dll_locked_i,
	output logic dll_ready_flag_o,
	output logic init_start_o,
	output logic sdram_drive_strength_o,
	output logic narrow_bus_select_o,
	output logic [2:0] cas_latency_field_o,
	output logic [3:0] bank_count_o,
	output logic [3:0] column_bits_o,
	output dcsr_pkg::dcsr_word_t timing_register_one_o,
	output dcsr_pkg::dcsr_word_t timing_register_two_o
);
	import dcsr_pkg::*;

	if (ADDR_WIDTH < 8) begin : g_bad_width
		$error("ADDR_WIDTH must be at least 8");
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode
	logic hit_status, hit_bank, hit_tim_one, hit_tim_two;
	logic bank_wr;
	assign hit_status = reg_addr_i == ADDR_WIDTH'(`DCSR_OFF_STATUS);
	assign hit_bank = reg_addr_i == ADDR_WIDTH'(`DCSR_OFF_BANK);
	assign hit_tim_one = reg_addr_i == ADDR_WIDTH'(`DCSR_OFF_TIMING_ONE);
	assign hit_tim_two = reg_addr_i == ADDR_WIDTH'(`DCSR_OFF_TIMING_TWO);
	assign bank_wr = reg_wr_i && hit_bank;

	////////////////////////////////////////////////////////////////////////
	// DLL status synchroniser; the first stage feeds only the second
	logic [2:0] dll_meta_q, dll_sync_q;
	logic dll_ready_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dll_meta_q <= 3'h0;
			dll_sync_q <= 3'h0;
		end else begin
			dll_meta_q <= {dll_powered_up_i, dll_in_reset_i, dll_locked_i};
			dll_sync_q <= dll_meta_q;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dll_ready_q <= 1'h0;
		end else begin
			dll_ready_q <= dll_sync_q[2] && !dll_sync_q[1] && dll_sync_q[0];
		end
	end
	assign dll_ready_flag_o = dll_ready_q;

	////////////////////////////////////////////////////////////////////////
	// Bank configuration fields
	logic drive_unlock_q, drive_q, timing_unlock_q, narrow_q;
	logic [3:0] rsvd_high_q;
	logic [2:0] cas_q, bank_code_q, page_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_unlock_q <= `DCSR_RST_DRIVE_UNLOCK;
			rsvd_high_q <= `DCSR_RST_RSVD_HIGH;
			timing_unlock_q <= `DCSR_RST_TIMING_UNLOCK;
			narrow_q <= `DCSR_RST_NARROW;
			cas_q <= `DCSR_RST_CAS;
			bank_code_q <= `DCSR_RST_BANKS;
			page_q <= `DCSR_RST_PAGE;
		end else if (bank_wr) begin
			drive_unlock_q <= reg_wdata_i[`DCSR_BANK_DRIVE_UNLOCK_BIT];
			rsvd_high_q <= reg_wdata_i[`DCSR_BANK_RSVD_HIGH_MSB:`DCSR_BANK_RSVD_HIGH_LSB];
			timing_unlock_q <= reg_wdata_i[`DCSR_BANK_TIMING_UNLOCK_BIT];
			narrow_q <= reg_wdata_i[`DCSR_BANK_NARROW_BIT];
			cas_q <= reg_wdata_i[`DCSR_BANK_CAS_MSB:`DCSR_BANK_CAS_LSB];
			bank_code_q <= reg_wdata_i[`DCSR_BANK_BANKS_MSB:`DCSR_BANK_BANKS_LSB];
			page_q <= reg_wdata_i[`DCSR_BANK_PAGE_MSB:`DCSR_BANK_PAGE_LSB];
		end
	end

	// Unlock is judged on the stored bit, so the value written with 0 lands
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_q <= `DCSR_RST_DRIVE;
		end else if (bank_wr && drive_unlock_q) begin
			drive_q <= reg_wdata_i[`DCSR_BANK_DRIVE_BIT];
		end
	end
	assign sdram_drive_strength_o = drive_q;
	assign narrow_bus_select_o = narrow_q;
	assign cas_latency_field_o = cas_q;

	// Every bank write restarts init, even one that only toggles the unlock
	logic init_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			init_q <= 1'h0;
		end else begin
			init_q <= bank_wr;
		end
	end
	assign init_start_o = init_q;

	////////////////////////////////////////////////////////////////////////
	// Geometry decode; reserved codes give zero
	logic [3:0] banks_q, cols_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			banks_q <= 4'h0;
		end else begin
			unique case (bank_code_q)
				3'h0: banks_q <= 4'h1;
				3'h1: banks_q <= 4'h2;
				3'h2: banks_q <= 4'h4;
				3'h3: banks_q <= 4'h8;
				default: banks_q <= 4'h0;
			endcase
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cols_q <= 4'h0;
		end else begin
			unique case (page_q)
				3'h0: cols_q <= 4'h8;
				3'h1: cols_q <= 4'h9;
				3'h2: cols_q <= 4'hA;
				3'h3: cols_q <= 4'hB;
				default: cols_q <= 4'h0;
			endcase
		end
	end
	assign bank_count_o = banks_q;
	assign column_bits_o = cols_q;

	////////////////////////////////////////////////////////////////////////
	// Timing registers
	dcsr_timing_if tif ();
	assign tif.wr_en = reg_wr_i && (hit_tim_one || hit_tim_two);
	assign tif.sel = hit_tim_two ? DCSR_TIM_TWO : DCSR_TIM_ONE;
	assign tif.wdata = reg_wdata_i;
	assign tif.unlock = timing_unlock_q;

	dcsr_timing_store u_timing (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.tif(tif)
	);
	assign timing_register_one_o = tif.data_one;
	assign timing_register_two_o = tif.data_two;

	////////////////////////////////////////////////////////////////////////
	// Read path; unmapped offsets read zero
	dcsr_word_t bank_word, rd_word_d, rdata_q;
	logic rvalid_q;
	assign bank_word = {8'h00, drive_unlock_q, rsvd_high_q, drive_q, `DCSR_BANK_RSVD_LOW,
		timing_unlock_q, narrow_q, 2'h0, cas_q, 2'h0, bank_code_q, 1'h0, page_q};
	always_comb begin
		rd_word_d = 32'h0000_0000;
		if (hit_status) begin
			rd_word_d[`DCSR_STAT_READY_BIT] = dll_ready_q;
		end else if (hit_bank) begin
			rd_word_d = bank_word;
		end else if (hit_tim_one) begin
			rd_word_d = tif.data_one;
		end else if (hit_tim_two) begin
			rd_word_d = tif.data_two;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'h0;
		end else begin
			rvalid_q <= reg_rd_i;
			if (reg_rd_i) begin
				rdata_q <= rd_word_d;
			end
		end
	end
	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	chk_ready_status: assert property (
		reg_rd_i && hit_status |=> reg_rdata_o == {29'h0, $past(dll_ready_q), 2'h0})
		else $error("status read does not show DLL ready");
	chk_ready_cause: assert property (
		!dll_sync_q[0] || dll_sync_q[1] || !dll_sync_q[2] |=> !dll_ready_flag_o)
		else $error("DLL ready without power, lock and reset release");
	chk_init_launch: assert property (
		bank_wr |=> init_start_o ##1 !init_start_o || $past(bank_wr))
		else $error("bank write did not launch init");
	chk_drive_locked: assert property (
		bank_wr && !drive_unlock_q |=> $stable(sdram_drive_strength_o)
			&& cas_latency_field_o == $past(reg_wdata_i[11:9]))
		else $error("locked write mishandled drive strength");
	chk_drive_open: assert property (
		bank_wr && drive_unlock_q |=> sdram_drive_strength_o == $past(reg_wdata_i[18]))
		else $error("unlocked write did not set drive strength");
	chk_unlock_seq: assert property (
		bank_wr && reg_wdata_i[23] ##1 bank_wr && !reg_wdata_i[23]
			|=> sdram_drive_strength_o == $past(reg_wdata_i[18]) && !bank_word[23])
		else $error("unlock sequence failed");
	chk_bus_width: assert property (
		bank_wr |=> narrow_bus_select_o == $past(reg_wdata_i[14]))
		else $error("bus width not taken");
	chk_bank_decode: assert property (
		bank_code_q == 3'h3 |=> bank_count_o == 4'h8)
		else $error("eight bank code decoded wrong");
	chk_col_decode: assert property (
		page_q == 3'h2 |=> column_bits_o == 4'hA)
		else $error("column width decoded wrong");

	cov_unlock_seq: cover property (bank_wr && reg_wdata_i[23] ##1 bank_wr && !reg_wdata_i[23]);
	cov_dll_ready: cover property (!dll_ready_flag_o ##1 dll_ready_flag_o);
	cov_timing_write: cover property (tif.wr_en && tif.unlock);
	cov_locked_timing: cover property (tif.wr_en && !tif.unlock);
endmodule
`default_nettype wire

// >>> sim/dcsr_dll_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcsr_dll_model (
	input wire logic clk_i,
	input wire logic [1:0] mode_i,
	input wire logic init_start_i,
	output logic dll_powered_up_o,
	output logic dll_in_reset_o,
	output logic dll_locked_o,
	output int init_count_o
);
	int launches = 0;
	// Mode 0 ready, 1 powered down, 2 held in reset, 3 not locked
	assign dll_powered_up_o = (mode_i != 2'h1);
	assign dll_in_reset_o = (mode_i == 2'h2);
	assign dll_locked_o = (mode_i == 2'h0);
	// Each launch of the memory setup sequence is counted once
	always @(posedge clk_i) begin
		if (init_start_i === 1'h1) begin
			launches <= launches + 1;
		end
	end
	assign init_count_o = launches;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
	import dcsr_pkg::*;
	logic clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic [7:0] reg_addr_i = 8'h00;
	dcsr_word_t reg_wdata_i = 32'h0000_0000;
	dcsr_word_t reg_rdata_o, timing_register_one_o, timing_register_two_o;
	logic reg_rvalid_o, dll_powered_up, dll_in_reset, dll_locked, dll_ready_flag_o;
	logic init_start_o, sdram_drive_strength_o, narrow_bus_select_o;
	logic [2:0] cas_latency_field_o;
	logic [3:0] bank_count_o, column_bits_o;
	logic [1:0] dll_mode = 2'h1;
	int init_count, miscompares = 0, comparisons = 0, cycles = 0;
	dcsr_word_t v;
	initial forever #2.5 clk_i = ~clk_i;
	dcsr_top dcsr_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.dll_powered_up_i(dll_powered_up), .dll_in_reset_i(dll_in_reset),
		.dll_locked_i(dll_locked), .dll_ready_flag_o(dll_ready_flag_o),
		.init_start_o(init_start_o), .sdram_drive_strength_o(sdram_drive_strength_o),
		.narrow_bus_select_o(narrow_bus_select_o), .cas_latency_field_o(cas_latency_field_o),
		.bank_count_o(bank_count_o), .column_bits_o(column_bits_o),
		.timing_register_one_o(timing_register_one_o),
		.timing_register_two_o(timing_register_two_o));
	dcsr_dll_model dcsr_dll_model_inst (.clk_i(clk_i), .mode_i(dll_mode),
		.init_start_i(init_start_o), .dll_powered_up_o(dll_powered_up),
		.dll_in_reset_o(dll_in_reset), .dll_locked_o(dll_locked), .init_count_o(init_count));
	////////////////////////////////////////////////////////////////////////////////
	// Reserved fields always carry their fixed values
	function automatic dcsr_word_t bank(logic ul, logic dr, logic tu, logic nar,
		logic [2:0] cas, logic [2:0] ib, logic [2:0] pg);
		return {8'h00, ul, 4'h2, dr, 2'h3, tu, nar, 2'h0, cas, 2'h0, ib, 1'h0, pg};
	endfunction
	task automatic wr(input logic [7:0] a, input dcsr_word_t d);
		@(negedge clk_i);
		reg_wr_i = 1'h1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_i);
		reg_wr_i = 1'h0;
		if (a == `DCSR_OFF_BANK) `CHK("init_start", 1'h1, init_start_o)
	endtask
	// Two writes on consecutive edges, strobe held high across both
	task automatic wr2(input logic [7:0] a, input dcsr_word_t d0, input dcsr_word_t d1);
		@(negedge clk_i);
		reg_wr_i = 1'h1;
		reg_addr_i = a;
		reg_wdata_i = d0;
		@(negedge clk_i);
		reg_wdata_i = d1;
		@(negedge clk_i);
		reg_wr_i = 1'h0;
		`CHK("init back to back", 1'h1, init_start_o)
	endtask
	task automatic rd(input logic [7:0] a, output dcsr_word_t d);
		@(negedge clk_i);
		reg_rd_i = 1'h1;
		reg_addr_i = a;
		@(negedge clk_i);
		reg_rd_i = 1'h0;
		`CHK("rvalid", 1'h1, reg_rvalid_o)
		d = reg_rdata_o;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(`DCSR_OFF_BANK, v);
		`CHK("bank reset", 32'h0017_0A20, v)
		`CHK("drive reset", 1'h1, sdram_drive_strength_o)
		`CHK("bank count reset", 4'h4, bank_count_o)
		`CHK("column reset", 4'h8, column_bits_o)
		@(negedge clk_i);
		`CHK("rvalid drop", 1'h0, reg_rvalid_o)
		$display("test reset done");
	endtask
	task automatic t_dll;
		for (int m = 3; m >= 0; m--) begin
			dll_mode = m[1:0];
			repeat (4) @(negedge clk_i);
			`CHK("ready flag", (m == 0), dll_ready_flag_o)
			rd(`DCSR_OFF_STATUS, v);
			`CHK("status", {29'h0, (m == 0), 2'h0}, v)
		end
		$display("test dll done");
	endtask
	// Drive bit moves only across an unlock, then relock, pair of writes
	task automatic t_drive;
		int n;
		n = init_count;
		wr(`DCSR_OFF_BANK, bank(1'h0, 1'h0, 1'h0, 1'h0, 3'h3, 3'h2, 3'h0));
		`CHK("drive locked", 1'h1, sdram_drive_strength_o)
		`CHK("cas while locked", 3'h3, cas_latency_field_o)
		rd(`DCSR_OFF_BANK, v);
		`CHK("bank locked", bank(1'h0, 1'h1, 1'h0, 1'h0, 3'h3, 3'h2, 3'h0), v)
		wr(`DCSR_OFF_BANK, bank(1'h1, 1'h1, 1'h0, 1'h0, 3'h4, 3'h2, 3'h0));
		wr(`DCSR_OFF_BANK, bank(1'h0, 1'h0, 1'h0, 1'h0, 3'h4, 3'h2, 3'h0));
		`CHK("drive normal", 1'h0, sdram_drive_strength_o)
		wr2(`DCSR_OFF_BANK, bank(1'h1, 1'h0, 1'h0, 1'h0, 3'h4, 3'h2, 3'h0),
			bank(1'h0, 1'h1, 1'h0, 1'h0, 3'h4, 3'h2, 3'h0));
		`CHK("drive weak", 1'h1, sdram_drive_strength_o)
		@(negedge clk_i);
		`CHK("init launches", n + 5, init_count)
		$display("test drive done");
	endtask
	task automatic t_decode;
		for (int k = 0; k < 5; k++) begin
			wr(`DCSR_OFF_BANK, bank(1'h0, 1'h0, 1'h0, k[0], 3'h5, k[2:0], k[2:0]));
			`CHK("narrow", k[0], narrow_bus_select_o)
			@(negedge clk_i);
			`CHK("bank count", (k < 4) ? 4'(1 << k) : 4'h0, bank_count_o)
			`CHK("column bits", (k < 4) ? 4'(8 + k) : 4'h0, column_bits_o)
		end
		$display("test decode done");
	endtask
	task automatic t_timing;
		wr(`DCSR_OFF_TIMING_ONE, 32'h1234_5678);
		`CHK("timing one locked", 32'h0000_0000, timing_register_one_o)
		wr(`DCSR_OFF_BANK, bank(1'h0, 1'h0, 1'h1, 1'h0, 3'h5, 3'h2, 3'h1));
		wr(`DCSR_OFF_TIMING_ONE, 32'h1234_5678);
		wr(`DCSR_OFF_TIMING_TWO, 32'h9ABC_DEF0);
		rd(`DCSR_OFF_TIMING_TWO, v);
		`CHK("timing two", 32'h9ABC_DEF0, v)
		`CHK("timing one", 32'h1234_5678, timing_register_one_o)
		wr(`DCSR_OFF_BANK, bank(1'h0, 1'h0, 1'h0, 1'h0, 3'h5, 3'h2, 3'h1));
		wr(`DCSR_OFF_TIMING_TWO, 32'h0000_0011);
		`CHK("timing two relocked", 32'h9ABC_DEF0, timing_register_two_o)
		rd(8'h40, v);
		`CHK("unmapped", 32'h0000_0000, v)
		$display("test timing done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// The whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		repeat (8) @(negedge clk_i);
		reset_n_i = 1'h1;
		t_reset();
		t_dll();
		t_drive();
		t_decode();
		t_timing();
		summarize();
	end
endmodule
`default_nettype wire
